// ==== common/can_buf_pkg.sv ====
package can_buf_pkg;
	// Register pages: address bits 7:4 pick a buffer, 3:0 its byte
	localparam logic [3:0] PAGE_TX2    = 4'h2;
	localparam logic [3:0] PAGE_RX0    = 4'h3;
	localparam logic [3:0] PAGE_RX1    = 4'h4;
	localparam logic [7:0] A_FILT      = 8'h50;
	localparam logic [7:0] A_MASK      = 8'h68;
	localparam logic [7:0] A_CTRL      = 8'h70;
	localparam logic [7:0] A_STAT      = 8'h71;
	localparam logic [7:0] A_CAP_BIT   = 8'h72;
	localparam logic [7:0] A_CAP_STATE = 8'h73;
	localparam logic [7:0] A_CAP_CNT   = 8'h74;
	localparam logic [7:0] A_IFLAG     = 8'h75;
	localparam logic [7:0] A_IEN       = 8'h76;
	// Buffer layout: byte 0 control, then id, length and data
	localparam logic [3:0] BUF_BYTES = 4'he;
	localparam logic [3:0] MAB_BYTES = 4'hd;
	localparam int B_SIDL = 2;
	localparam int B_DLC  = 5;
	// Control byte fields
	localparam int TXC_ABT  = 6;
	localparam int TXC_LARB = 5;
	localparam int TXC_ERR  = 4;
	localparam int TXC_REQ  = 3;
	localparam logic [7:0] TXC_WMASK = 8'h0f;
	localparam logic [7:0] RX0_WMASK = 8'h64;
	localparam logic [7:0] RX1_WMASK = 8'h60;
	localparam int RXC_RTR  = 3;
	localparam int RX0_ROLL = 2;
	localparam int SIDL_EXT = 3;
	localparam int DLC_RTR  = 6;
	localparam int CTRL_ABORT_ALL_REQUEST = 4;
	// Flag register bits; transmit buffer n sits at F_TX0 + n
	localparam int F_RX0    = 0;
	localparam int F_RX1    = 1;
	localparam int F_TX0    = 2;
	localparam int F_BUSERR = 5;
	localparam int F_OVF    = 6;
	// Modes
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_LOOP   = 3'h2;
	localparam logic [2:0] MODE_CONFIG = 3'h4;
	localparam logic [7:0] CTRL_RESET  = 8'h80;
	localparam logic [1:0] RXM_STD = 2'h1;
	localparam logic [1:0] RXM_EXT = 2'h2;
	localparam logic [1:0] RXM_ANY = 2'h3;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_LOOP = 3'b100
	} tx_state_t;
endpackage

// ==== rtl/can_msg_buffers.sv ====
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
module can_msg_buffers (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       bus_idle,
	input  wire logic       eng_tx_bit,
	input  wire logic       tx_ok,
	input  wire logic       tx_lost,
	input  wire logic       tx_err,
	input  wire logic [3:0] tx_byte_idx,
	output logic      [7:0] tx_byte,
	output logic      [1:0] tx_sel,
	output logic            tx_go,
	input  wire logic       mab_we,
	input  wire logic [3:0] mab_idx,
	input  wire logic [7:0] mab_wdata,
	input  wire logic       mab_done,
	input  wire logic       mab_error,
	input  wire logic       err_sample_bit,
	input  wire logic [7:0] err_state_vec,
	input  wire logic [7:0] protocol_bit_counter,
	output logic            bus_transmit_pin,
	output logic            tx_pin_port_mode,
	output logic            silent,
	output logic            irq
);

	////////////////////////////////////////////////////////////////
	// Storage and state

	logic [7:0] tx_mem [0:2][0:13];
	logic [7:0] rx_mem [0:1][0:13];
	logic [7:0] message_assembly_buffer [0:12];
	logic [31:0] filt [0:5];
	logic [31:0] mask [0:1];
	logic [7:0] ctrl;
	logic [2:0] operating_mode_status;
	logic [1:0] ovfl;
	logic [7:0] iflag;
	logic [7:0] ien;
	logic [7:0] cap_bit;
	logic [7:0] cap_state;
	logic [7:0] cap_cnt;
	logic [2:0] abort_pend;
	logic       loop_done;
	can_buf_pkg::tx_state_t state;

	////////////////////////////////////////////////////////////////
	// Functions

	// Masked identifier compare plus frame format gate
	function automatic logic accept(input logic [31:0] f, input logic [31:0] m,
		input logic [31:0] id, input logic [1:0] receive_mode_field);
		logic ext;
		logic fext;
		logic fmt;
		logic [31:0] diff;
		ext  = id[16 + can_buf_pkg::SIDL_EXT];
		fext = f[16 + can_buf_pkg::SIDL_EXT];
		diff = (id ^ f) & m;
		if (receive_mode_field == can_buf_pkg::RXM_STD)
			fmt = !ext && !fext;
		else if (receive_mode_field == can_buf_pkg::RXM_EXT)
			fmt = ext && fext;
		else
			fmt = ext == fext;
		accept = (receive_mode_field == can_buf_pkg::RXM_ANY) ||
			(fmt && diff[31:21] == 11'h000 && (!ext || diff[17:0] == 18'h00000));
	endfunction

	// Highest priority queued buffer; >= hands ties to the higher number
	function automatic logic [1:0] pick(input logic [2:0] req, input logic [5:0] pr);
		logic [1:0] best;
		logic [1:0] bp;
		best = 2'h0;
		bp   = 2'h0;
		for (int i = 0; i < 3; i++) begin
			if (req[i] && (!req[best] || pr[2*i +: 2] >= bp)) begin
				best = 2'(i);
				bp   = pr[2*i +: 2];
			end
		end
		pick = best;
	endfunction

	////////////////////////////////////////////////////////////////
	// Register decode

	wire [3:0] page     = reg_addr[7:4];
	wire [3:0] bidx     = reg_addr[3:0];
	wire       cfg      = operating_mode_status == can_buf_pkg::MODE_CONFIG;
	wire       is_tx    = page <= can_buf_pkg::PAGE_TX2 && bidx < can_buf_pkg::BUF_BYTES;
	wire       is_rx0   = page == can_buf_pkg::PAGE_RX0 && bidx < can_buf_pkg::BUF_BYTES;
	wire       is_rx1   = page == can_buf_pkg::PAGE_RX1 && bidx < can_buf_pkg::BUF_BYTES;
	wire       is_filt  = reg_addr >= can_buf_pkg::A_FILT && reg_addr < can_buf_pkg::A_MASK;
	wire       is_mask  = reg_addr >= can_buf_pkg::A_MASK && reg_addr < can_buf_pkg::A_CTRL;
	wire [7:0] foff     = reg_addr - can_buf_pkg::A_FILT;
	wire [7:0] moff     = reg_addr - can_buf_pkg::A_MASK;
	wire [1:0] tpage    = page[1:0];
	wire       in_loop  = operating_mode_status == can_buf_pkg::MODE_LOOP;
	wire [2:0] req_vec  = {tx_mem[2][0][can_buf_pkg::TXC_REQ],
		tx_mem[1][0][can_buf_pkg::TXC_REQ], tx_mem[0][0][can_buf_pkg::TXC_REQ]};
	wire [5:0] prio_vec = {tx_mem[2][0][1:0], tx_mem[1][0][1:0], tx_mem[0][0][1:0]};
	wire       abort_all = reg_wr && reg_addr == can_buf_pkg::A_CTRL
		&& reg_wdata[can_buf_pkg::CTRL_ABORT_ALL_REQUEST];

	// Read mux; filters and masks read as zero outside configuration
	wire [7:0] next_rdata =
		is_tx ? tx_mem[tpage][bidx] :
		is_rx0 ? rx_mem[0][bidx] :
		is_rx1 ? rx_mem[1][bidx] :
		(is_filt && cfg) ? filt[foff[4:2]][8*(3-foff[1:0]) +: 8] :
		(is_mask && cfg) ? mask[moff[2]][8*(3-moff[1:0]) +: 8] :
		reg_addr == can_buf_pkg::A_CTRL ? ctrl :
		reg_addr == can_buf_pkg::A_STAT ? {operating_mode_status, 3'h0, ovfl} :
		reg_addr == can_buf_pkg::A_CAP_BIT ? cap_bit :
		reg_addr == can_buf_pkg::A_CAP_STATE ? cap_state :
		reg_addr == can_buf_pkg::A_CAP_CNT ? cap_cnt :
		reg_addr == can_buf_pkg::A_IFLAG ? iflag :
		reg_addr == can_buf_pkg::A_IEN ? ien : 8'h00;

	////////////////////////////////////////////////////////////////
	// Transmit scheduling

	wire busy   = state != can_buf_pkg::ST_IDLE;
	wire can_tx = operating_mode_status == can_buf_pkg::MODE_NORMAL || in_loop;
	wire launch = state == can_buf_pkg::ST_IDLE && can_tx && |req_vec
		&& (bus_idle || in_loop);
	wire in_send = state == can_buf_pkg::ST_SEND;
	// Loopback ignores the acknowledge slot, so its frame always succeeds
	wire ev_ok   = (in_send && tx_ok) || state == can_buf_pkg::ST_LOOP;
	wire ev_lost = in_send && tx_lost;
	wire ev_err  = in_send && tx_err && !tx_ok;

	// Buffer choice is frozen at start of frame
	always_ff @(posedge mclk) begin
		if (reset) begin
			state  <= can_buf_pkg::ST_IDLE;
			tx_sel <= 2'h0;
			tx_go  <= 1'b0;
		end else begin
			tx_go <= 1'b0;
			case (state)
				can_buf_pkg::ST_IDLE: begin
					if (launch) begin
						tx_sel <= pick(req_vec, prio_vec);
						tx_go  <= !in_loop;
						state  <= in_loop ? can_buf_pkg::ST_LOOP : can_buf_pkg::ST_SEND;
					end
				end
				can_buf_pkg::ST_SEND: begin
					if (tx_ok || tx_lost || tx_err)
						state <= can_buf_pkg::ST_IDLE;
				end
				default: state <= can_buf_pkg::ST_IDLE;
			endcase
		end
	end

	// Transmit buffers; completion events are written last so they win
	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int n = 0; n < 3; n++)
				for (int b = 0; b < 14; b++)
					tx_mem[n][b] <= 8'h00;
			abort_pend <= 3'h0;
		end else begin
			if (reg_wr && is_tx && bidx == 4'h0) begin
				tx_mem[tpage][0][3:0] <= reg_wdata[3:0];
				// Every write of a set request clears the old outcome, even a repeat
				if (reg_wdata[can_buf_pkg::TXC_REQ]) begin
					tx_mem[tpage][0][can_buf_pkg::TXC_ABT]  <= 1'b0;
					tx_mem[tpage][0][can_buf_pkg::TXC_LARB] <= 1'b0;
					tx_mem[tpage][0][can_buf_pkg::TXC_ERR]  <= 1'b0;
				end else if (!reg_wdata[can_buf_pkg::TXC_REQ] && req_vec[tpage]) begin
					if (busy && tx_sel == tpage)
						abort_pend[tpage] <= 1'b1;
					else
						tx_mem[tpage][0][can_buf_pkg::TXC_ABT] <= 1'b1;
				end
			end else if (reg_wr && is_tx && !req_vec[tpage]) begin
				tx_mem[tpage][bidx] <= reg_wdata;
			end
			for (int n = 0; n < 3; n++) begin
				if (abort_all && req_vec[n]) begin
					tx_mem[n][0][can_buf_pkg::TXC_REQ] <= 1'b0;
					if (busy && tx_sel == 2'(n))
						abort_pend[n] <= 1'b1;
					else
						tx_mem[n][0][can_buf_pkg::TXC_ABT] <= 1'b1;
				end
			end
			if (ev_ok) begin
				tx_mem[tx_sel][0][can_buf_pkg::TXC_REQ] <= 1'b0;
				tx_mem[tx_sel][0][can_buf_pkg::TXC_ABT] <= 1'b0;
				abort_pend[tx_sel] <= 1'b0;
			end else if (ev_lost || ev_err) begin
				if (ev_lost)
					tx_mem[tx_sel][0][can_buf_pkg::TXC_LARB] <= 1'b1;
				else
					tx_mem[tx_sel][0][can_buf_pkg::TXC_ERR] <= 1'b1;
				if (abort_pend[tx_sel]) begin
					tx_mem[tx_sel][0][can_buf_pkg::TXC_ABT] <= 1'b1;
					tx_mem[tx_sel][0][can_buf_pkg::TXC_REQ] <= 1'b0;
				end
				abort_pend[tx_sel] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Assembly buffer and acceptance

	wire [31:0] mab_id = {message_assembly_buffer[0], message_assembly_buffer[1], message_assembly_buffer[2], message_assembly_buffer[3]};
	wire [1:0]  rxm0   = rx_mem[0][0][6:5];
	wire [1:0]  rxm1   = rx_mem[1][0][6:5];
	wire        full0  = iflag[can_buf_pkg::F_RX0];
	wire        full1  = iflag[can_buf_pkg::F_RX1];
	wire        roll_en = rx_mem[0][0][can_buf_pkg::RX0_ROLL];
	wire [5:0]  hit;

	// Filters 0 and 1 use mask 0 for buffer zero; 2 to 5 use mask 1
	for (genvar i = 0; i < 6; i++) begin : g_hit
		assign hit[i] = accept(filt[i], mask[i < 2 ? 0 : 1], mab_id,
			i < 2 ? rxm0 : rxm1);
	end

	wire       msg_in = mab_done || loop_done;
	wire       en0    = msg_in ? (hit[0] || hit[1]) : (mab_error && rxm0 == can_buf_pkg::RXM_ANY);
	wire       en1    = msg_in ? |hit[5:2] : (mab_error && rxm1 == can_buf_pkg::RXM_ANY);
	wire       to0    = en0 && !full0;
	wire       roll   = en0 && full0 && roll_en && !full1;
	wire       to1    = roll || (!en0 && en1 && !full1);
	wire       ovf0   = en0 && full0 && !roll_en;
	wire       ovf1   = (en0 && full0 && roll_en && full1) || (!en0 && en1 && full1);
	// Lowest numbered match is reported
	wire [2:0] hit0   = hit[0] ? 3'h0 : 3'h1;
	wire [2:0] hit1   = roll ? hit0 : hit[2] ? 3'h2 : hit[3] ? 3'h3 : hit[4] ? 3'h4 : 3'h5;
	wire       rtr    = message_assembly_buffer[can_buf_pkg::B_DLC - 1][can_buf_pkg::DLC_RTR];

	// The assembly buffer takes every frame; loopback fills it from the sent buffer
	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int b = 0; b < 13; b++)
				message_assembly_buffer[b] <= 8'h00;
			loop_done <= 1'b0;
		end else begin
			loop_done <= state == can_buf_pkg::ST_LOOP;
			if (state == can_buf_pkg::ST_LOOP) begin
				for (int b = 0; b < 13; b++)
					message_assembly_buffer[b] <= tx_mem[tx_sel][b + 1];
			end else if (mab_we && mab_idx < can_buf_pkg::MAB_BYTES) begin
				message_assembly_buffer[mab_idx] <= mab_wdata;
			end
		end
	end

	// Receive buffers: whole copy, control low bits hold hit and remote flag
	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int n = 0; n < 2; n++)
				for (int b = 0; b < 14; b++)
					rx_mem[n][b] <= 8'h00;
		end else begin
			if (reg_wr && is_rx0 && bidx == 4'h0)
				rx_mem[0][0] <= (rx_mem[0][0] & ~can_buf_pkg::RX0_WMASK)
					| (reg_wdata & can_buf_pkg::RX0_WMASK);
			if (reg_wr && is_rx1 && bidx == 4'h0)
				rx_mem[1][0] <= (rx_mem[1][0] & ~can_buf_pkg::RX1_WMASK)
					| (reg_wdata & can_buf_pkg::RX1_WMASK);
			if (to0) begin
				for (int b = 0; b < 13; b++)
					rx_mem[0][b + 1] <= message_assembly_buffer[b];
				rx_mem[0][0][can_buf_pkg::RXC_RTR] <= rtr;
				rx_mem[0][0][0] <= hit0[0];
			end
			if (to1) begin
				for (int b = 0; b < 13; b++)
					rx_mem[1][b + 1] <= message_assembly_buffer[b];
				rx_mem[1][0][can_buf_pkg::RXC_RTR] <= rtr;
				rx_mem[1][0][2:0] <= hit1;
			end
		end
	end

	// Error snapshot for the debug receive mode
	always_ff @(posedge mclk) begin
		if (reset) begin
			cap_bit   <= 8'h00;
			cap_state <= 8'h00;
			cap_cnt   <= 8'h00;
		end else if (mab_error && (rxm0 == can_buf_pkg::RXM_ANY
			|| rxm1 == can_buf_pkg::RXM_ANY)) begin
			cap_bit   <= {7'h00, err_sample_bit};
			cap_state <= err_state_vec;
			cap_cnt   <= protocol_bit_counter;
		end
	end

	////////////////////////////////////////////////////////////////
	// Filters, masks, control

	// Acceptance setup only changes in configuration mode
	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < 6; i++)
				filt[i] <= 32'h0;
			mask <= '{32'h0, 32'h0};
		end else if (reg_wr && cfg) begin
			if (is_filt)
				filt[foff[4:2]][8*(3-foff[1:0]) +: 8] <= reg_wdata;
			if (is_mask)
				mask[moff[2]][8*(3-moff[1:0]) +: 8] <= reg_wdata;
		end
	end

	// Abort-all is acted on at once and never stored
	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl   <= can_buf_pkg::CTRL_RESET;
			operating_mode_status <= can_buf_pkg::MODE_CONFIG;
			ien    <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == can_buf_pkg::A_CTRL)
				ctrl <= reg_wdata & ~(8'h01 << can_buf_pkg::CTRL_ABORT_ALL_REQUEST);
			if (reg_wr && reg_addr == can_buf_pkg::A_IEN)
				ien <= reg_wdata;
			if (!busy && !launch)
				operating_mode_status <= ctrl[7:5];
		end
	end

	// Sticky flags: a write of 0 clears a bit, a new event in the same cycle wins
	always_ff @(posedge mclk) begin
		if (reset) begin
			iflag <= 8'h00;
			ovfl  <= 2'h0;
		end else begin
			iflag <= ((reg_wr && reg_addr == can_buf_pkg::A_IFLAG) ? (iflag & reg_wdata) : iflag)
				| (8'(to0) << can_buf_pkg::F_RX0)
				| (8'(to1) << can_buf_pkg::F_RX1)
				| (8'(ev_ok) << (can_buf_pkg::F_TX0 + 32'(tx_sel)))
				| (8'(ev_err) << can_buf_pkg::F_BUSERR)
				| (8'(ovf0 || ovf1) << can_buf_pkg::F_OVF);
			ovfl <= ((reg_wr && reg_addr == can_buf_pkg::A_STAT) ? (ovfl & reg_wdata[1:0]) : ovfl)
				| {ovf1, ovf0};
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs, all registered

	always_ff @(posedge mclk) begin
		if (reset) begin
			reg_rdata        <= 8'h00;
			tx_byte          <= 8'h00;
			bus_transmit_pin <= 1'b1;
			tx_pin_port_mode <= 1'b0;
			silent           <= 1'b0;
			irq              <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
			tx_byte   <= tx_byte_idx < can_buf_pkg::BUF_BYTES ? tx_mem[tx_sel][tx_byte_idx] : 8'h00;
			// Recessive and handed to the port while looping back
			bus_transmit_pin <= in_loop ? 1'b1 : eng_tx_bit;
			tx_pin_port_mode <= in_loop;
			silent           <= in_loop;
			irq              <= |(iflag & ien);
		end
	end

endmodule

// ==== verification/can_engine_model.sv ====
`timescale 1ns/1ps
module can_engine_model (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       tx_go,
	input  wire logic [1:0] tx_sel,
	output logic            bus_idle,
	output logic            eng_tx_bit,
	output logic            tx_ok,
	output logic            tx_lost,
	output logic            tx_err,
	output logic      [3:0] tx_byte_idx,
	output logic            mab_we,
	output logic      [3:0] mab_idx,
	output logic      [7:0] mab_wdata,
	output logic            mab_done,
	output logic            mab_error,
	output logic            err_sample_bit,
	output logic      [7:0] err_state_vec,
	output logic      [7:0] protocol_bit_counter
);
	int         credits;
	int         delay;
	int         left;
	logic [1:0] end_kind;
	logic       busy;
	logic [1:0] launches[$];
	initial begin
		{credits, delay, left, end_kind, busy} = '0;
		{tx_ok, tx_lost, tx_err, eng_tx_bit, tx_byte_idx} = 8'h08;
		{mab_we, mab_idx, mab_wdata, mab_done, mab_error} = '0;
		{err_sample_bit, err_state_vec, protocol_bit_counter} = '0;
	end
	////////////////////////////////////////
	// Bus is offered only as often as the bench grants frames
	assign bus_idle = !busy && credits > 0;
	// One frame per launch; ends after the set delay as ok, lost or error
	always @(posedge mclk) begin
		tx_ok   <= 1'b0;
		tx_lost <= 1'b0;
		tx_err  <= 1'b0;
		eng_tx_bit  <= busy ? ~eng_tx_bit : 1'b1;
		tx_byte_idx <= busy ? tx_byte_idx + 4'h1 : 4'h0;
		if (reset) begin
			busy <= 1'b0;
		end else if (tx_go) begin
			launches.push_back(tx_sel);
			credits = credits - 1;
			busy <= 1'b1;
			left <= delay;
		end else if (busy && left > 0) begin
			left <= left - 1;
		end else if (busy) begin
			busy    <= 1'b0;
			tx_ok   <= end_kind == 2'h0;
			tx_lost <= end_kind == 2'h1;
			tx_err  <= end_kind == 2'h2;
		end
	end
	////////////////////////////////////////
	// Incoming frame: id high byte then zeros; a failing frame stops early
	task automatic rx_frame(input logic [7:0] sidh, input logic fail);
		for (int i = 0; i < (fail ? 2 : 13); i++) begin
			@(posedge mclk);
			mab_we    <= 1'b1;
			mab_idx   <= 4'(i);
			mab_wdata <= (i == 0) ? sidh : 8'h00;
		end
		@(posedge mclk);
		mab_we     <= 1'b0;
		mab_wdata  <= ~mab_wdata;
		mab_done   <= !fail;
		mab_error  <= fail;
		err_sample_bit       <= 1'b1;
		err_state_vec        <= 8'hc3;
		protocol_bit_counter <= 8'h2a;
		@(posedge mclk);
		mab_done  <= 1'b0;
		mab_error <= 1'b0;
	endtask
endmodule

// ==== verification/can_msg_buffers_props.sv ====
`timescale 1ns/1ps
module can_msg_buffers_props (
	input wire logic       mclk,
	input wire logic       reset,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       bus_idle,
	input wire logic       eng_tx_bit,
	input wire logic [1:0] tx_sel,
	input wire logic       tx_go,
	input wire logic       bus_transmit_pin,
	input wire logic       tx_pin_port_mode,
	input wire logic       silent
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	// Loopback keeps the pin recessive and the engine quiet
	AST_LOOP_PIN_HIGH: assert property (tx_pin_port_mode |-> bus_transmit_pin)
		else $error("pin driven while in loopback");
	AST_LOOP_SILENT: assert property (silent == tx_pin_port_mode)
		else $error("silent flag out of step with loopback");
	AST_LOOP_NO_LAUNCH: assert property (tx_pin_port_mode |-> !tx_go)
		else $error("frame launched onto bus in loopback");
	// Outside loopback the pin is the engine bit one cycle late
	AST_PIN_FOLLOWS: assert property (!tx_pin_port_mode && !$past(tx_pin_port_mode)
		&& !$past(reset) |-> bus_transmit_pin == $past(eng_tx_bit))
		else $error("pin does not follow engine bit");
	////////////////////////////////////////
	// Launch only into a free bus, one pulse, valid buffer
	AST_GO_NEEDS_BUS: assert property (tx_go |-> $past(bus_idle))
		else $error("launch without bus available");
	AST_GO_PULSE: assert property (tx_go |=> !tx_go)
		else $error("launch pulse longer than one cycle");
	AST_SEL_RANGE: assert property (tx_go |-> tx_sel != 2'h3)
		else $error("launch of a buffer that does not exist");
	AST_SEL_HOLD: assert property (!tx_go && !tx_pin_port_mode |-> $stable(tx_sel))
		else $error("selected buffer changed mid frame");
	// Read data only in the cycle after a read strobe
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	COV_LAUNCH: cover property (tx_go);
	COV_LOOP: cover property ($rose(tx_pin_port_mode));
	COV_READ: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
	logic       mclk, reset, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata;
	wire  [7:0] reg_rdata, tx_byte, err_state_vec, protocol_bit_counter, mab_wdata;
	wire  [3:0] tx_byte_idx, mab_idx;
	wire  [1:0] tx_sel;
	wire        bus_idle, eng_tx_bit, tx_ok, tx_lost, tx_err, tx_go, mab_we;
	wire        mab_done, mab_error, err_sample_bit;
	wire        bus_transmit_pin, tx_pin_port_mode, silent, irq;
	int         n_fail, tests_run;
	can_msg_buffers i_can_msg_buffers (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.bus_idle(bus_idle), .eng_tx_bit(eng_tx_bit), .tx_ok(tx_ok), .tx_lost(tx_lost),
		.tx_err(tx_err), .tx_byte_idx(tx_byte_idx), .tx_byte(tx_byte), .tx_sel(tx_sel),
		.tx_go(tx_go), .mab_we(mab_we), .mab_idx(mab_idx), .mab_wdata(mab_wdata),
		.mab_done(mab_done), .mab_error(mab_error), .err_sample_bit(err_sample_bit),
		.err_state_vec(err_state_vec), .protocol_bit_counter(protocol_bit_counter),
		.bus_transmit_pin(bus_transmit_pin), .tx_pin_port_mode(tx_pin_port_mode),
		.silent(silent), .irq(irq));
	can_engine_model i_can_engine_model (.mclk(mclk), .reset(reset), .tx_go(tx_go),
		.tx_sel(tx_sel), .bus_idle(bus_idle), .eng_tx_bit(eng_tx_bit), .tx_ok(tx_ok),
		.tx_lost(tx_lost), .tx_err(tx_err), .tx_byte_idx(tx_byte_idx), .mab_we(mab_we),
		.mab_idx(mab_idx), .mab_wdata(mab_wdata), .mab_done(mab_done),
		.mab_error(mab_error), .err_sample_bit(err_sample_bit),
		.err_state_vec(err_state_vec), .protocol_bit_counter(protocol_bit_counter));
	////////////////////////////////////////
	// Register bus: strobes one cycle, read data taken in the following cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHECK(d, e)
	endtask
	task automatic wait_mode(input logic [2:0] m);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 20 && s[7:5] !== m; i++)
			rd(8'h71, s);
		`CHECK(s[7:5], m)
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Grant frames to the engine model and set how they end
	task automatic setm(input int c, input logic [1:0] k, input int dl);
		@(negedge mclk);
		i_can_engine_model.credits  = c;
		i_can_engine_model.end_kind = k;
		i_can_engine_model.delay    = dl;
	endtask
	task automatic wait_go(input int n);
		for (int i = 0; i < 200 && i_can_engine_model.launches.size() < n; i++)
			@(negedge mclk);
		`CHECK(i_can_engine_model.launches.size(), n)
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		rdchk(8'h70, 8'h80);
		rdchk(8'h71, 8'h80);
		rdchk(8'h7f, 8'h00);
		`CHECK({silent, tx_pin_port_mode, bus_transmit_pin, irq}, 4'h2)
	endtask
	// Masks all ones; filters 0,1 for rx0, filters 2,3 share one id
	task automatic t_config();
		for (int i = 0; i < 8; i++)
			wr(8'h68 + 8'(i), 8'hff);
		wr(8'h50, 8'h11);
		wr(8'h54, 8'h22);
		wr(8'h58, 8'h33);
		wr(8'h5c, 8'h33);
		rdchk(8'h58, 8'h33);
		wr(8'h76, 8'h7f);
		wr(8'h70, 8'h00);
		wait_mode(3'h0);
		rdchk(8'h58, 8'h00);
	endtask
	task automatic t_prio();
		setm(0, 2'h0, 3);
		wr(8'h01, 8'ha0);
		wr(8'h05, 8'h01);
		wr(8'h00, 8'h09);
		wr(8'h10, 8'h0b);
		wr(8'h20, 8'h0b);
		setm(3, 2'h0, 3);
		wait_go(3);
		settle(8);
		`CHECK(i_can_engine_model.launches[0], 2'h2)
		`CHECK(i_can_engine_model.launches[1], 2'h1)
		`CHECK(i_can_engine_model.launches[2], 2'h0)
		rdchk(8'h75, 8'h1c);
		rdchk(8'h00, 8'h01);
		`CHECK(tx_byte, 8'h01)
		`CHECK(irq, 1'b1)
		wr(8'h75, 8'h00);
		settle(2);
		`CHECK(irq, 1'b0)
	endtask
	// Error, idle abort, abort on lost arbitration, abort lost to success, abort-all
	task automatic t_fail();
		setm(1, 2'h2, 3);
		wr(8'h00, 8'h08);
		wait_go(4);
		settle(8);
		rdchk(8'h00, 8'h18);
		rdchk(8'h75, 8'h20);
		`CHECK(irq, 1'b1)
		wr(8'h75, 8'h00);
		wr(8'h00, 8'h08);
		rdchk(8'h00, 8'h08);
		wr(8'h00, 8'h00);
		rdchk(8'h00, 8'h40);
		setm(1, 2'h1, 6);
		wr(8'h00, 8'h08);
		wait_go(5);
		wr(8'h00, 8'h00);
		settle(10);
		rdchk(8'h00, 8'h60);
		setm(1, 2'h0, 6);
		settle(8);
		`CHECK(i_can_engine_model.launches.size(), 5)
		wr(8'h00, 8'h08);
		wait_go(6);
		wr(8'h00, 8'h00);
		settle(10);
		rdchk(8'h00, 8'h00);
		wr(8'h10, 8'h08);
		wr(8'h20, 8'h08);
		wr(8'h70, 8'h10);
		rdchk(8'h10, 8'h40);
		rdchk(8'h20, 8'h40);
	endtask
	task automatic t_loop();
		setm(1, 2'h0, 3);
		wr(8'h75, 8'h00);
		wr(8'h70, 8'h40);
		wait_mode(3'h2);
		`CHECK({tx_pin_port_mode, bus_transmit_pin, silent}, 3'h7)
		wr(8'h01, 8'h11);
		wr(8'h05, 8'h02);
		wr(8'h06, 8'h5a);
		wr(8'h07, 8'ha5);
		wr(8'h00, 8'h08);
		settle(10);
		`CHECK(i_can_engine_model.launches.size(), 6)
		rdchk(8'h75, 8'h05);
		rdchk(8'h31, 8'h11);
		rdchk(8'h36, 8'h5a);
		rdchk(8'h37, 8'ha5);
		rdchk(8'h30, 8'h00);
		wr(8'h70, 8'h00);
		wait_mode(3'h0);
	endtask
	// Receive buffer zero full: rollover, overflow; then emptied: filter choice, modes
	task automatic t_rx();
		wr(8'h75, 8'h01);
		wr(8'h30, 8'h04);
		i_can_engine_model.rx_frame(8'h11, 1'b0);
		settle(4);
		rdchk(8'h40, 8'h00);
		rdchk(8'h41, 8'h11);
		rdchk(8'h71, 8'h00);
		i_can_engine_model.rx_frame(8'h22, 1'b0);
		settle(4);
		rdchk(8'h71, 8'h02);
		rdchk(8'h75, 8'h43);
		wr(8'h71, 8'h00);
		wr(8'h75, 8'h00);
		wr(8'h30, 8'h00);
		i_can_engine_model.rx_frame(8'h33, 1'b0);
		settle(4);
		rdchk(8'h40, 8'h02);
		rdchk(8'h75, 8'h02);
		wr(8'h75, 8'h00);
		i_can_engine_model.rx_frame(8'h44, 1'b0);
		settle(4);
		rdchk(8'h75, 8'h00);
		wr(8'h40, 8'h40);
		i_can_engine_model.rx_frame(8'h33, 1'b0);
		settle(4);
		rdchk(8'h75, 8'h00);
		wr(8'h30, 8'h60);
		i_can_engine_model.rx_frame(8'h77, 1'b1);
		settle(4);
		rdchk(8'h75, 8'h01);
		rdchk(8'h31, 8'h77);
		rdchk(8'h72, 8'h01);
		rdchk(8'h73, 8'hc3);
		rdchk(8'h74, 8'h2a);
	endtask
	////////////////////////////////////////
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always #10 mclk = ~mclk;
	initial begin
		{mclk, reset, reg_wr, reg_rd, reg_addr, reg_wdata} = 20'h40000;
		{n_fail, tests_run} = '0;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_config();
		t_prio();
		t_fail();
		t_loop();
		t_rx();
		wrap_up();
	end
	// The whole run needs well under 2000 cycles; a hang is cut at 10000
	initial begin
		#200000;
		n_fail++;
		wrap_up();
	end
endmodule
bind can_msg_buffers can_msg_buffers_props i_can_msg_buffers_props (.mclk(mclk),
	.reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_idle(bus_idle),
	.eng_tx_bit(eng_tx_bit), .tx_sel(tx_sel), .tx_go(tx_go),
	.bus_transmit_pin(bus_transmit_pin), .tx_pin_port_mode(tx_pin_port_mode),
	.silent(silent));
